// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rxtd_pkg::*;
;
	logic        i_clock = 1'b0;
	logic        i_rst_b = 1'b0;
	logic [5:0]  i_reg_addr = 6'h00;
	logic        i_reg_wr = 1'b0;
	logic [7:0]  i_reg_wdata = 8'h00;
	logic [7:0]  o_reg_rdata;
	rxtd_mod_t   i_mod_format = RXTD_MOD_FSK;
	logic        i_tx_mode = 1'b0;
	logic [15:0] i_wake_event_period = 16'h0001;
	logic [1:0]  i_wake_timer_resolution = 2'h0;
	logic        i_rx_start = 1'b0;
	logic        i_rx_end = 1'b0;
	logic        i_sync_found = 1'b0;
	logic        i_preamble_quality_indicator = 1'b0;
	logic        i_carrier_sense = 1'b0;
	logic        i_symbol_tick = 1'b0;
	logic [10:0] o_dev_steps;
	logic        o_dev_apply;
	logic [3:0]  o_msk_eighths;
	logic        o_msk_apply;
	logic        o_rx_searching;
	logic        o_rx_locked;
	logic        o_rx_abort;
	logic [17:0] o_wor_duty_ppm;
	logic        o_wor_duty_na;
	int          errors = 0;
	int          tests_run = 0;
	int          aborts = 0;
	logic [31:0] seed = 32'hF5360F50;
	logic [7:0]  rdv;
	logic [31:0] r;
	real         base [4] = '{3.6058, 18.0288, 32.4519, 46.8750};
	rxtd_cfg rxtd_cfg_inst (
		.i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_mod_format(i_mod_format),
		.i_tx_mode(i_tx_mode), .i_wake_event_period(i_wake_event_period),
		.i_wake_timer_resolution(i_wake_timer_resolution), .i_rx_start(i_rx_start),
		.i_rx_end(i_rx_end), .i_sync_found(i_sync_found),
		.i_preamble_quality_indicator(i_preamble_quality_indicator),
		.i_carrier_sense(i_carrier_sense),
		.i_symbol_tick(i_symbol_tick), .o_dev_steps(o_dev_steps), .o_dev_apply(o_dev_apply),
		.o_msk_eighths(o_msk_eighths), .o_msk_apply(o_msk_apply),
		.o_rx_searching(o_rx_searching), .o_rx_locked(o_rx_locked), .o_rx_abort(o_rx_abort),
		.o_wor_duty_ppm(o_wor_duty_ppm), .o_wor_duty_na(o_wor_duty_na));
	always #4 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		if (o_rx_abort === 1'b1) begin
			aborts <= aborts + 1;
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected search length in clocks from the coefficient table
	function automatic int to_cyc(int ev, int res, int sel);
		return int'(ev * base[res] / (2.0 ** sel) * 26.0 / 26.0 * 125.0);
	endfunction
	function automatic logic [31:0] duty_na(int res, int sel);
		return (res > 1 || sel == 7 || (res == 1 && sel > 3)) ? 32'h1 : 32'h0;
	endfunction
	function automatic logic [31:0] duty_ppm(int res, int sel);
		int t1 [4] = '{19531, 9765, 4883, 2441};
		return (res == 0) ? (32'h0001E848 >> sel) : t1[sel];
	endfunction
	task automatic close_out;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		repeat (3) @(posedge i_clock);
		#1;
		d = o_reg_rdata;
	endtask
	// Start a search and wait for lock or abort, then check outcome and length
	task automatic run_rx(input logic exp_lock, input int lo, input int hi);
		int n;
		n = 0;
		@(posedge i_clock);
		i_rx_start <= 1'b1;
		@(posedge i_clock);
		i_rx_start <= 1'b0;
		while (n < 20000 && o_rx_abort !== 1'b1 && o_rx_locked !== 1'b1) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		if (n >= 20000) begin
			errors++;
			close_out();
		end
		chk("rx_locked", {31'h0, exp_lock}, {31'h0, o_rx_locked});
		chk("rx_length_ok", 32'h1, {31'h0, (n >= lo && n <= hi)});
		@(posedge i_clock);
		i_rx_end <= 1'b1;
		@(posedge i_clock);
		i_rx_end <= 1'b0;
		repeat (2) @(posedge i_clock);
	endtask
	initial begin
		#720000;
		errors++;
		close_out();
	end
	initial begin
		int c;
		int a0;
		repeat (20) @(posedge i_clock);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_clock);
		rd(6'h15, rdv);
		chk("dev_reset", 32'h47, {24'h0, rdv});
		rd(6'h16, rdv);
		chk("tocfg_reset", 32'h07, {24'h0, rdv});
		rd(6'h3F, rdv);
		chk("unmapped", 32'h00, {24'h0, rdv});
		for (int i = 0; i < 12; i++) begin
			r = (i == 0) ? 32'h0 : (i == 1) ? 32'hFF : xs();
			i_mod_format <= rxtd_mod_t'(i % 3);
			i_tx_mode <= i[2];
			wr(6'h15, r[7:0]);
			rd(6'h15, rdv);
			chk("dev_reg", {24'h0, r[7:0] & 8'h77}, {24'h0, rdv});
			chk("dev_steps", {28'h1, r[2:0]} << r[6:4], {21'h0, o_dev_steps});
			chk("msk_eighths", r[2:0] + 32'h1, {28'h0, o_msk_eighths});
			chk("dev_apply", {31'h0, i % 3 == 0}, {31'h0, o_dev_apply});
			chk("msk_apply", {31'h0, i[2] && i % 3 == 1}, {31'h0, o_msk_apply});
		end
		i_mod_format <= RXTD_MOD_FSK;
		for (int res = 0; res < 4; res++) begin
			for (int sel = 0; sel < 8; sel++) begin
				r = xs();
				i_wake_timer_resolution <= res[1:0];
				wr(6'h16, {r[7:3], sel[2:0]});
				rd(6'h16, rdv);
				chk("tocfg_reg", {24'h0, r[7:0] & 8'hF8 & 8'h1F | sel[7:0]}, {24'h0, rdv});
				chk("duty_na", duty_na(res, sel), {31'h0, o_wor_duty_na});
				if (duty_na(res, sel) == 32'h0) begin
					chk("duty_ppm", duty_ppm(res, sel), {14'h0, o_wor_duty_ppm});
				end
			end
		end
		for (int i = 0; i < 7; i++) begin
			r = xs();
			a0 = (i == 0) ? 0 : r[1:0];
			c = (i == 0) ? 0 : 1 + r[7:4] % 6;
			i_wake_timer_resolution <= a0[1:0];
			i_wake_event_period <= 16'h0001 + (i == 6);
			wr(6'h16, {5'h0, c[2:0]});
			c = to_cyc(1 + (i == 6), a0, c);
			run_rx(1'b0, c - 2, c + 6);
		end
		i_wake_timer_resolution <= 2'h0;
		i_wake_event_period <= 16'h0001;
		for (int k = 0; k < 16; k++) begin
			i_preamble_quality_indicator <= k[0];
			i_carrier_sense <= k[2];
			wr(6'h16, {3'h0, k[3], k[1], 3'h6});
			run_rx(k[1] && k[0] && (!k[3] || k[2]), 2, 14);
		end
		i_sync_found <= 1'b1;
		wr(6'h16, 8'h00);
		run_rx(1'b1, 1, 3);
		i_sync_found <= 1'b0;
		i_preamble_quality_indicator <= 1'b0;
		wr(6'h16, 8'h07);
		a0 = aborts;
		@(posedge i_clock);
		i_rx_start <= 1'b1;
		@(posedge i_clock);
		i_rx_start <= 1'b0;
		repeat (3000) @(posedge i_clock);
		#1;
		chk("no_timeout", a0, aborts);
		chk("still_search", 32'h1, {31'h0, o_rx_searching});
		i_mod_format <= RXTD_MOD_ASK;
		wr(6'h16, 8'h17);
		for (int cs = 1; cs >= 0; cs--) begin
			i_carrier_sense <= cs[0];
			@(posedge i_clock);
			i_rx_start <= 1'b1;
			@(posedge i_clock);
			i_rx_start <= 1'b0;
			for (int t = 0; t < 8; t++) begin
				a0 = aborts;
				repeat (3) @(posedge i_clock);
				chk("early_abort", a0, aborts);
				i_symbol_tick <= 1'b1;
				@(posedge i_clock);
				i_symbol_tick <= 1'b0;
			end
			repeat (5) @(posedge i_clock);
			#1;
			chk("ask_cs_abort", a0 + (cs == 0), aborts);
		end
		close_out();
	end
endmodule
`default_nettype wire

// File: hw/rxtd_acc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rxtd_acc_timer #(
	parameter int ACC_W  = 48,
	parameter int STEP_W = 24
) (
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst_b,
	// Control
	input  wire logic              i_clear,
	input  wire logic              i_run,
	input  wire logic [ACC_W-1:0]  i_target,
	input  wire logic [STEP_W-1:0] i_step,
	// Status
	output logic                   o_expired
);

	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic             exp_q;
	logic             exp_d;

	// Fractional accumulation keeps the timeout exact without a divider
	always_comb begin
		acc_d = acc_q;
		exp_d = exp_q;
		if (i_clear) begin
			acc_d = '0;
			exp_d = 1'b0;
		end else if (i_run && !exp_q) begin
			acc_d = acc_q + ACC_W'(i_step);
			if (acc_d >= i_target)
				exp_d = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acc_q <= '0;
			exp_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			exp_q <= exp_d;
		end
	end

	assign o_expired = exp_q;

endmodule
`default_nettype wire

// File: hw/rxtd_cfg.sv
// Operation
// (RQ1) FSK deviation uses mantissa with implicit one
// (RQ2) Mantissa bits 2:0, reset value seven
// (RQ3) MSK: mantissa selects phase-change eighths
// (RQ4) Deviation ignored for ASK and MSK receive
// (RQ5) Host programs deviation near incoming signal
// (RQ6) Carrier-sense bit ends reception on no carrier
// (RQ7) ASK: timeout without carrier in eight symbols
// (RQ8) Expiry needs sync, or preamble quality if qualified
// (RQ9) Three-bit timeout scales with wake period, resets seven
// (RQ10) Timeout is event times coefficient times 26/X
// (RQ11) Coefficient per resolution, halving per setting
// (RQ12) Setting seven disables the sync search timeout
// (RQ13) Host uses resolution zero or one with wake
// (RQ14) Wake duty cycle table per setting and resolution
// (RQ15) Unmet qualifier on expiry abandons reception
`timescale 1ns/1ps
`default_nettype none
`include "rxtd_defines.svh"
module rxtd_cfg
	import rxtd_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	// Register port
	input  wire logic [5:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	// Radio context
	input  wire rxtd_mod_t   i_mod_format,
	input  wire logic        i_tx_mode,
	input  wire logic [15:0] i_wake_event_period,
	input  wire logic [1:0]  i_wake_timer_resolution,
	// Receive events
	input  wire logic        i_rx_start,
	input  wire logic        i_rx_end,
	input  wire logic        i_sync_found,
	input  wire logic        i_preamble_quality_indicator,
	input  wire logic        i_carrier_sense,
	input  wire logic        i_symbol_tick,
	// Deviation results
	output logic [10:0]      o_dev_steps,
	output logic             o_dev_apply,
	output logic [3:0]       o_msk_eighths,
	output logic             o_msk_apply,
	// Receive control
	output logic             o_rx_searching,
	output logic             o_rx_locked,
	output logic             o_rx_abort,
	// Wake duty cycle
	output logic [17:0]      o_wor_duty_ppm,
	output logic             o_wor_duty_na
);

	logic [1:0]  rst_sync_q;
	logic        rst_b;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_b = rst_sync_q[1];

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!rst_b);

	// Registers
	logic [7:0] devn_q, devn_d;
	logic [7:0] tocfg_q, tocfg_d;
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		devn_d  = devn_q;
		tocfg_d = tocfg_q;
		if (i_reg_wr && i_reg_addr == `RXTD_ADDR_DEVN)
			devn_d = i_reg_wdata & `RXTD_DEVN_MASK;
		if (i_reg_wr && i_reg_addr == `RXTD_ADDR_TOCFG)
			tocfg_d = i_reg_wdata & `RXTD_TOCFG_MASK;
		case (i_reg_addr)
			`RXTD_ADDR_DEVN:  rdata_d = devn_q;
			`RXTD_ADDR_TOCFG: rdata_d = tocfg_q;
			default:          rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_b) begin
		if (!rst_b) begin
			devn_q  <= `RXTD_DEVN_RST; // RQ2
			tocfg_q <= `RXTD_TOCFG_RST; // RQ9
			rdata_q <= 8'h00;
		end else begin
			devn_q  <= devn_d;
			tocfg_q <= tocfg_d;
			rdata_q <= rdata_d;
		end
	end
	assign o_reg_rdata = rdata_q;

	logic [2:0] dev_m;
	logic [2:0] dev_e;
	logic [2:0] to_sel;
	logic       to_qual;
	logic       cs_term;

	assign dev_m   = devn_q[`RXTD_DEV_M_LSB +: 3];
	assign dev_e   = devn_q[`RXTD_DEV_E_LSB +: 3];
	assign to_sel  = tocfg_q[`RXTD_TO_SEL_LSB +: 3];
	assign to_qual = tocfg_q[`RXTD_TO_QUAL_BIT];
	assign cs_term = tocfg_q[`RXTD_TO_CS_BIT];

	// Deviation in units of crystal / 2^17
	logic [10:0] dev_steps_q, dev_steps_d;
	logic        dev_apply_q, dev_apply_d;
	logic [3:0]  msk_q, msk_d;
	logic        msk_apply_q, msk_apply_d;

	always_comb begin
		dev_steps_d = 11'({`RXTD_DEV_IMPLICIT, dev_m}) << dev_e; // RQ1
		msk_d       = 4'(dev_m) + 4'h1; // RQ3
		dev_apply_d = i_mod_format == RXTD_MOD_FSK; // RQ4
		msk_apply_d = i_tx_mode && i_mod_format == RXTD_MOD_MSK; // RQ3 RQ4
	end

	always_ff @(posedge i_clock or negedge rst_b) begin
		if (!rst_b) begin
			dev_steps_q <= 11'h000;
			dev_apply_q <= 1'b0;
			msk_q       <= 4'h0;
			msk_apply_q <= 1'b0;
		end else begin
			dev_steps_q <= dev_steps_d;
			dev_apply_q <= dev_apply_d;
			msk_q       <= msk_d;
			msk_apply_q <= msk_apply_d;
		end
	end
	assign o_dev_steps   = dev_steps_q;
	assign o_dev_apply   = dev_apply_q;
	assign o_msk_eighths = msk_q;
	assign o_msk_apply   = msk_apply_q;

	// Timeout target and per-clock step of the accumulator
	logic [47:0] to_target;
	logic [23:0] to_step;
	logic [3:0]  coef_k;
	logic        tmr_exp;

	assign coef_k    = {i_wake_timer_resolution, 2'h1}; // RQ11
	assign to_target = 48'(i_wake_event_period) * 48'(coef_k) * 48'(`RXTD_COEF_NUM) // RQ10
		* 48'(`RXTD_TO_SCALE) * 48'(`RXTD_CLK_MHZ);
	assign to_step   = 24'(`RXTD_COEF_DEN * `RXTD_XTAL_MHZ) << to_sel; // RQ11

	rxtd_state_t state_q, state_d;

	rxtd_acc_timer #(
		.ACC_W  (48),
		.STEP_W (24)
	) u_timer (
		.i_clock   (i_clock),
		.i_rst_b   (rst_b),
		.i_clear   (i_rx_start || state_q != RXTD_ST_SEARCH),
		.i_run     (state_q == RXTD_ST_SEARCH && to_sel != `RXTD_NO_TIMEOUT), // RQ9 RQ12
		.i_target  (to_target),
		.i_step    (to_step),
		.o_expired (tmr_exp)
	);

	// Receive qualification
	logic [3:0] sym_q, sym_d;
	logic       cs_seen_q, cs_seen_d;
	logic       abort_q, abort_d;
	logic       ask_fail;
	logic       qual_ok;

	assign ask_fail = cs_term && i_mod_format == RXTD_MOD_ASK && !cs_seen_q
		&& sym_q == `RXTD_ASK_CS_SYMBOLS; // RQ7
	assign qual_ok  = (i_sync_found || (to_qual && i_preamble_quality_indicator)) // RQ8
		&& (!cs_term || i_carrier_sense); // RQ6

	always_comb begin
		state_d   = state_q;
		sym_d     = sym_q;
		cs_seen_d = cs_seen_q;
		abort_d   = 1'b0;
		case (state_q)
			RXTD_ST_IDLE: begin
				sym_d     = 4'h0;
				cs_seen_d = 1'b0;
			end
			RXTD_ST_SEARCH: begin
				if (i_carrier_sense)
					cs_seen_d = 1'b1;
				if (i_symbol_tick && sym_q != `RXTD_ASK_CS_SYMBOLS)
					sym_d = sym_q + 4'h1;
				if (i_sync_found) begin
					state_d = RXTD_ST_LOCKED;
				end else if (ask_fail) begin
					state_d = RXTD_ST_IDLE; // RQ7
					abort_d = 1'b1;
				end else if (tmr_exp) begin
					if (qual_ok) begin
						state_d = RXTD_ST_LOCKED; // RQ8
					end else begin
						state_d = RXTD_ST_IDLE; // RQ15
						abort_d = 1'b1;
					end
				end
			end
			RXTD_ST_LOCKED: begin
				if (i_rx_end)
					state_d = RXTD_ST_IDLE;
			end
			default: begin
				state_d = RXTD_ST_IDLE;
			end
		endcase
		if (i_rx_start) begin
			state_d   = RXTD_ST_SEARCH;
			sym_d     = 4'h0;
			cs_seen_d = 1'b0;
			abort_d   = 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q   <= RXTD_ST_IDLE;
			sym_q     <= 4'h0;
			cs_seen_q <= 1'b0;
			abort_q   <= 1'b0;
		end else begin
			state_q   <= state_d;
			sym_q     <= sym_d;
			cs_seen_q <= cs_seen_d;
			abort_q   <= abort_d;
		end
	end
	assign o_rx_searching = state_q == RXTD_ST_SEARCH;
	assign o_rx_locked    = state_q == RXTD_ST_LOCKED;
	assign o_rx_abort     = abort_q;

	// Wake duty cycle estimate
	logic [17:0] duty_q, duty_d;
	logic        na_q, na_d;

	always_comb begin
		duty_d = 18'h00000;
		na_d   = 1'b0;
		case (i_wake_timer_resolution)
			2'h0: begin
				duty_d = `RXTD_DUTY_RES0_PPM >> to_sel; // RQ14
				na_d   = to_sel == `RXTD_NO_TIMEOUT;
			end
			2'h1: begin
				case (to_sel)
					3'h0:    duty_d = `RXTD_DUTY_RES1_PPM;
					3'h1:    duty_d = `RXTD_DUTY_RES1_S1_PPM;
					3'h2:    duty_d = `RXTD_DUTY_RES1_S2_PPM;
					3'h3:    duty_d = `RXTD_DUTY_RES1_S3_PPM;
					default: na_d   = 1'b1; // RQ14
				endcase
			end
			default: begin
				na_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_b) begin
		if (!rst_b) begin
			duty_q <= 18'h00000;
			na_q   <= 1'b1;
		end else begin
			duty_q <= duty_d;
			na_q   <= na_d;
		end
	end
	assign o_wor_duty_ppm = duty_q;
	assign o_wor_duty_na  = na_q;

	mant_reset_a: assert property ($rose(rst_b) |-> devn_q[2:0] == 3'h7 && to_sel == 3'h7) // RQ2
		else $error("deviation or timeout field not seven after reset");
	dev_formula_a: assert property ($stable(devn_q) [*3] |-> // RQ1
		o_dev_steps == (11'({1'b1, dev_m}) << dev_e))
		else $error("deviation steps do not match mantissa and exponent");
	msk_frac_a: assert property ($stable(devn_q) [*3] |-> o_msk_eighths == 4'(dev_m) + 4'h1) // RQ3
		else $error("phase-change eighths wrong");
	dev_ignore_a: assert property (i_mod_format != RXTD_MOD_FSK |=> !o_dev_apply // RQ4
		&& (o_msk_apply == $past(i_tx_mode && i_mod_format == RXTD_MOD_MSK)))
		else $error("deviation applied outside FSK");
	no_timeout_a: assert property (o_rx_searching && to_sel == 3'h7 && !ask_fail // RQ12
		&& !i_rx_start |=> !o_rx_abort)
		else $error("abort with timeout disabled");
	sync_only_a: assert property (o_rx_searching && tmr_exp && !i_sync_found && !i_rx_start // RQ8
		&& !(to_qual && i_preamble_quality_indicator) |=> o_rx_abort ##1 !o_rx_abort)
		else $error("expiry without sync did not abort");
	preamble_accept_a: assert property (o_rx_searching && tmr_exp && to_qual && !i_rx_start // RQ8
		&& !ask_fail
		&& i_preamble_quality_indicator && (!cs_term || i_carrier_sense) |=> o_rx_locked)
		else $error("qualified expiry did not lock");
	ask_window_a: assert property (o_rx_searching && ask_fail && !i_sync_found // RQ7
		&& !i_rx_start |=> o_rx_abort && !o_rx_searching)
		else $error("no carrier in eight symbols did not abort");
	abort_idle_a: assert property (o_rx_abort |-> !o_rx_searching && !o_rx_locked) // RQ15
		else $error("abort while still receiving");

endmodule
`default_nettype wire

// File: shared/rxtd_defines.svh
`ifndef RXTD_DEFINES_SVH
`define RXTD_DEFINES_SVH

// Register offsets on the serial register port
`define RXTD_ADDR_DEVN        6'h15
`define RXTD_ADDR_TOCFG       6'h16

// Reset values
`define RXTD_DEVN_RST         8'h47
`define RXTD_TOCFG_RST        8'h07

// Field positions
`define RXTD_DEV_M_LSB        0
`define RXTD_DEV_E_LSB        4
`define RXTD_TO_SEL_LSB       0
`define RXTD_TO_QUAL_BIT      3
`define RXTD_TO_CS_BIT        4
`define RXTD_DEVN_MASK        8'h77
`define RXTD_TOCFG_MASK       8'h1F

// Deviation mantissa implicit leading one
`define RXTD_DEV_IMPLICIT     1'h1

// Timeout: us = event * C * 26 / X, C = 750 * k / 208 / 2^sel, k = 4 * res + 1
`define RXTD_COEF_NUM         750
`define RXTD_COEF_DEN         208
`define RXTD_TO_SCALE         26
`define RXTD_XTAL_MHZ         26
`define RXTD_CLK_MHZ          125
`define RXTD_NO_TIMEOUT       3'h7

// Amplitude keying carrier sense window in symbols
`define RXTD_ASK_CS_SYMBOLS   4'h8

// Wake duty cycle in ppm, resolution zero and resolution one settings zero to three
`define RXTD_DUTY_RES0_PPM    18'h1E848
`define RXTD_DUTY_RES1_PPM    18'h04C4B
`define RXTD_DUTY_RES1_S1_PPM 18'h02625
`define RXTD_DUTY_RES1_S2_PPM 18'h01313
`define RXTD_DUTY_RES1_S3_PPM 18'h00989

`endif

// File: shared/rxtd_pkg.sv
package rxtd_pkg;

	typedef enum logic [1:0] {
		RXTD_MOD_FSK = 2'h0,
		RXTD_MOD_MSK = 2'h1,
		RXTD_MOD_ASK = 2'h2
	} rxtd_mod_t;

	typedef enum logic [2:0] {
		RXTD_ST_IDLE   = 3'h1,
		RXTD_ST_SEARCH = 3'h2,
		RXTD_ST_LOCKED = 3'h4
	} rxtd_state_t;

endpackage
